// file: common/pps_pkg.sv
/*
  Shared constants and types for the hub downstream port power,
  overcurrent qualification and port split block.
  Assumes a 40 MHz core clock and byte-wide configuration accesses.
*/
`default_nettype none
package pps_pkg;
  localparam int NUM_PORTS = 6;
  localparam int NUM_SPLIT_GPIO = 4;
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_KHZ * TICK_MS;

  localparam logic [15:0] ADDR_LOCKOUT = 16'h30E1;
  localparam logic [15:0] ADDR_MIN_WIDTH = 16'h30EA;
  localparam logic [15:0] ADDR_WINDOW = 16'h30EB;
  localparam logic [15:0] ADDR_SPLIT_EN = 16'h3C48;
  localparam logic [15:0] ADDR_GLOBAL = 16'h4141;
  localparam logic [15:0] ADDR_SEL_P4 = 16'h416E;
  localparam logic [15:0] ADDR_SEL_P5 = 16'h416F;

  localparam logic [7:0] RST_LOCKOUT = 8'h0A;
  localparam logic [7:0] RST_WINDOW = 8'h14;
  localparam logic [3:0] RST_MIN_WIDTH = 4'h5;
  localparam logic [7:0] RST_SPLIT_EN = 8'h00;
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] RST_SEL = 8'h00;

  localparam logic [7:0] SPLIT_EN_MASK = 8'h60;
  localparam logic [7:0] GLOBAL_MASK = 8'h01;
  localparam logic [3:0] MIN_WIDTH_MASK = 4'hF;
  localparam int BIT_SPLIT_P4 = 5;
  localparam int BIT_SPLIT_P5 = 6;
  localparam int BIT_GLOBAL = 0;
  localparam int PORT4_IDX = 3;
  localparam int PORT5_IDX = 4;

  localparam logic [7:0] SEL_P4_OPT_A = 8'h42;
  localparam logic [7:0] SEL_P4_OPT_B = 8'h05;
  localparam logic [7:0] SEL_P5_OPT_A = 8'h06;
  localparam logic [7:0] SEL_P5_OPT_B = 8'h04;

  localparam int GP66 = 0;
  localparam int GP5 = 1;
  localparam int GP6 = 2;
  localparam int GP4 = 3;

  typedef struct packed {
    logic [7:0] lockout;
    logic [7:0] window;
    logic [3:0] min_width;
  } pps_ocs_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic otp;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pps_cfg_req_t;

  typedef enum logic [1:0] {
    OCS_OFF,
    OCS_LOCKOUT,
    OCS_WATCH,
    OCS_TRIPPED
  } pps_ocs_state_t;
endpackage : pps_pkg
`default_nettype wire

// file: src/pps_ocs_port.sv
/*
  Overcurrent qualifier for one downstream port: turn-on lockout,
  single long low pulse and double short low pulse detection.
  Assumes sense_low_i is already synchronised and tick_i is a 1 ms pulse.
*/
`default_nettype none
module pps_ocs_port
  import pps_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic tick_i,
  input wire logic power_on_i,
  input wire logic sense_low_i,
  input wire pps_ocs_cfg_t cfg_i,
  output logic oc_event_o,
  output logic oc_tripped_o
);
  typedef struct packed {
    pps_ocs_state_t st;
    logic [7:0] lock_cnt;
    logic [3:0] run_cnt;
    logic [7:0] win_cnt;
    logic low_d;
    logic event_p;
    logic tripped;
  } pps_ocs_st_t;

  pps_ocs_st_t r_reg;
  pps_ocs_st_t r_next;
  logic fall;

  assign fall = sense_low_i && !r_reg.low_d;
  assign oc_event_o = r_reg.event_p;
  assign oc_tripped_o = r_reg.tripped;

  always_comb begin
    r_next = r_reg;
    r_next.event_p = 1'b0;
    r_next.low_d = sense_low_i;
    if (!power_on_i) begin
      r_next = '0;
      r_next.st = OCS_OFF;
    end else begin
      unique case (r_reg.st)
        OCS_OFF: begin
          r_next.st = OCS_LOCKOUT;
          r_next.lock_cnt = cfg_i.lockout;
        end
        OCS_LOCKOUT: begin
          // Pin level ignored until the lockout count runs out
          if (tick_i) begin
            if (r_reg.lock_cnt <= 8'h01) begin
              r_next.st = OCS_WATCH;
              r_next.lock_cnt = 8'h00;
            end else begin
              r_next.lock_cnt = r_reg.lock_cnt - 8'h01;
            end
          end
        end
        OCS_WATCH: begin
          // Low level is overcurrent for a switch flag and a blown fuse alike
          if (!sense_low_i) begin
            r_next.run_cnt = 4'h0;
          end else if (tick_i && r_reg.run_cnt != 4'hF) begin
            r_next.run_cnt = r_reg.run_cnt + 4'h1;
          end
          if (tick_i && r_reg.win_cnt != 8'h00) begin
            r_next.win_cnt = r_reg.win_cnt - 8'h01;
          end
          if (sense_low_i && r_reg.run_cnt >= cfg_i.min_width) begin
            r_next.st = OCS_TRIPPED;
            r_next.event_p = 1'b1;
          end else if (fall) begin
            if (r_reg.win_cnt != 8'h00) begin
              r_next.st = OCS_TRIPPED;
              r_next.event_p = 1'b1;
            end else begin
              r_next.win_cnt = cfg_i.window;
            end
          end
        end
        OCS_TRIPPED: begin
          r_next.st = OCS_TRIPPED;
        end
      endcase
    end
    // Registered copy so the trip level leaves the block from a flop
    r_next.tripped = (r_next.st == OCS_TRIPPED);
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  sequence s_power_up;
    !power_on_i ##1 power_on_i;
  endsequence

  property p_power_up_locks;
    @(posedge clock_i) disable iff (!nrst_i)
    s_power_up |=> (r_reg.st == OCS_LOCKOUT) && (r_reg.lock_cnt == $past(cfg_i.lockout));
  endproperty
  a_power_up_locks: assert property (p_power_up_locks)
    else $error("lockout not loaded at power on");

  property p_lockout_quiet;
    @(posedge clock_i) disable iff (!nrst_i)
    (r_reg.st == OCS_LOCKOUT) |=> !oc_event_o;
  endproperty
  a_lockout_quiet: assert property (p_lockout_quiet)
    else $error("overcurrent raised during lockout");

  property p_single_trip;
    @(posedge clock_i) disable iff (!nrst_i)
    (r_reg.st == OCS_WATCH && power_on_i && sense_low_i && r_reg.run_cnt >= cfg_i.min_width)
      |=> oc_event_o ##1 !oc_event_o;
  endproperty
  a_single_trip: assert property (p_single_trip)
    else $error("long low pulse not reported");

  property p_double_trip;
    @(posedge clock_i) disable iff (!nrst_i)
    (r_reg.st == OCS_WATCH && power_on_i && fall && r_reg.win_cnt != 8'h00)
      |=> oc_event_o && oc_tripped_o;
  endproperty
  a_double_trip: assert property (p_double_trip)
    else $error("second pulse in window not reported");

  property p_off_idle;
    @(posedge clock_i) disable iff (!nrst_i)
    !power_on_i |=> !oc_event_o && (r_reg.st == OCS_OFF);
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("sensing active with power off");
endmodule : pps_ocs_port
`default_nettype wire

// file: src/pps_top.sv
/*
  Downstream port power control, overcurrent qualification and port
  split configuration for ports 4 and 5 of a hub.
  Assumes configuration accesses come from the SMBus or OTP loader on
  the core clock, and the sense pins arrive asynchronously.
*/
`default_nettype none
module pps_top
  import pps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire pps_cfg_req_t cfg_req_i,
  input wire logic cfg_stage_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic [NUM_PORTS-1:0] port_power_on_i,
  input wire logic [1:0] ss_power_on_i,
  input wire logic [NUM_PORTS-1:0] port_power_sense_pin_i,
  output logic [NUM_PORTS-1:0] port_power_sense_pin_o,
  output logic [NUM_PORTS-1:0] port_power_sense_pin_oe_n_o,
  output logic [NUM_PORTS-1:0] port_pullup_en_o,
  output logic [NUM_PORTS-1:0] overcurrent_event_o,
  output logic [NUM_PORTS-1:0] overcurrent_tripped_o,
  output logic [NUM_SPLIT_GPIO-1:0] split_superspeed_power_pin_o,
  output logic [NUM_SPLIT_GPIO-1:0] split_superspeed_power_fn_o
);
  typedef struct packed {
    logic [NUM_PORTS-1:0] sync1;
    logic [NUM_PORTS-1:0] sync2;
    logic [NUM_PORTS-1:0] pwr;
    logic [NUM_PORTS-1:0] pin_lvl;
    logic [15:0] tick_cnt;
    logic tick;
    logic [7:0] lockout;
    logic [7:0] window;
    logic [3:0] min_width;
    logic [7:0] split_en;
    logic [7:0] glob;
    logic [7:0] sel4;
    logic [7:0] sel5;
    logic [7:0] rdata;
    logic [NUM_SPLIT_GPIO-1:0] gpio_fn;
    logic [NUM_SPLIT_GPIO-1:0] gpio_val;
  } pps_top_st_t;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES_P - 1);

  pps_top_st_t r_reg;
  pps_top_st_t r_next;
  pps_ocs_cfg_t ocs_cfg;
  logic wr_ok;
  logic split4_on;
  logic split5_on;

  assign ocs_cfg = '{lockout: r_reg.lockout, window: r_reg.window,
                     min_width: r_reg.min_width};
  // Configuration only lands during the configuration stage or an OTP load
  assign wr_ok = cfg_req_i.wr && (cfg_stage_i || cfg_req_i.otp);
  assign split4_on = r_reg.glob[BIT_GLOBAL] && r_reg.split_en[BIT_SPLIT_P4];
  assign split5_on = r_reg.glob[BIT_GLOBAL] && r_reg.split_en[BIT_SPLIT_P5];

  assign cfg_rdata_o = r_reg.rdata;
  assign port_power_sense_pin_o = r_reg.pin_lvl;
  assign port_power_sense_pin_oe_n_o = r_reg.pwr;
  assign port_pullup_en_o = r_reg.pwr;
  assign split_superspeed_power_pin_o = r_reg.gpio_val;
  assign split_superspeed_power_fn_o = r_reg.gpio_fn;

  always_comb begin
    r_next = r_reg;
    r_next.sync1 = port_power_sense_pin_i;
    r_next.sync2 = r_reg.sync1;
    // Power off: driver pulls the pin low, pull-up off; on: open drain
    r_next.pwr = port_power_on_i;
    r_next.pin_lvl = '0;

    // Millisecond tick shared by every port timer
    r_next.tick = 1'b0;
    if (r_reg.tick_cnt >= TICK_LAST) begin
      r_next.tick_cnt = 16'h0000;
      r_next.tick = 1'b1;
    end else begin
      r_next.tick_cnt = r_reg.tick_cnt + 16'h0001;
    end

    if (wr_ok) begin
      unique case (cfg_req_i.addr)
        ADDR_LOCKOUT: r_next.lockout = cfg_req_i.wdata;
        ADDR_WINDOW: r_next.window = cfg_req_i.wdata;
        ADDR_MIN_WIDTH: r_next.min_width = cfg_req_i.wdata[3:0] & MIN_WIDTH_MASK;
        ADDR_SPLIT_EN: r_next.split_en = cfg_req_i.wdata & SPLIT_EN_MASK;
        ADDR_GLOBAL: r_next.glob = cfg_req_i.wdata & GLOBAL_MASK;
        ADDR_SEL_P4: r_next.sel4 = cfg_req_i.wdata;
        ADDR_SEL_P5: r_next.sel5 = cfg_req_i.wdata;
        default: r_next.rdata = r_reg.rdata;
      endcase
    end

    if (cfg_req_i.rd) begin
      unique case (cfg_req_i.addr)
        ADDR_LOCKOUT: r_next.rdata = r_reg.lockout;
        ADDR_WINDOW: r_next.rdata = r_reg.window;
        ADDR_MIN_WIDTH: r_next.rdata = {4'h0, r_reg.min_width};
        ADDR_SPLIT_EN: r_next.rdata = r_reg.split_en;
        ADDR_GLOBAL: r_next.rdata = r_reg.glob;
        ADDR_SEL_P4: r_next.rdata = r_reg.sel4;
        ADDR_SEL_P5: r_next.rdata = r_reg.sel5;
        default: r_next.rdata = 8'h00;
      endcase
    end

    // Split pins carry the superspeed half only, output only
    r_next.gpio_fn[GP66] = split4_on && (r_reg.sel4 == SEL_P4_OPT_A);
    r_next.gpio_fn[GP5] = split4_on && (r_reg.sel4 == SEL_P4_OPT_B);
    r_next.gpio_fn[GP6] = split5_on && (r_reg.sel5 == SEL_P5_OPT_A);
    r_next.gpio_fn[GP4] = split5_on && (r_reg.sel5 == SEL_P5_OPT_B);
    r_next.gpio_val[GP66] = r_next.gpio_fn[GP66] && ss_power_on_i[0];
    r_next.gpio_val[GP5] = r_next.gpio_fn[GP5] && ss_power_on_i[0];
    r_next.gpio_val[GP6] = r_next.gpio_fn[GP6] && ss_power_on_i[1];
    r_next.gpio_val[GP4] = r_next.gpio_fn[GP4] && ss_power_on_i[1];
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= '0;
      r_reg.lockout <= RST_LOCKOUT;
      r_reg.window <= RST_WINDOW;
      r_reg.min_width <= RST_MIN_WIDTH;
      r_reg.split_en <= RST_SPLIT_EN;
      r_reg.glob <= RST_GLOBAL;
      r_reg.sel4 <= RST_SEL;
      r_reg.sel5 <= RST_SEL;
    end else begin
      r_reg <= r_next;
    end
  end

  // One qualifier per port, fed from the second synchroniser stage
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    pps_ocs_port u_ocs (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .tick_i(r_reg.tick),
      .power_on_i(r_reg.pwr[p]),
      .sense_low_i(!r_reg.sync2[p]),
      .cfg_i(ocs_cfg),
      .oc_event_o(overcurrent_event_o[p]),
      .oc_tripped_o(overcurrent_tripped_o[p])
    );

    property p_pin_off;
      @(posedge clock_i) disable iff (!nrst_i)
      !port_power_on_i[p] |=> !port_power_sense_pin_oe_n_o[p] && !port_pullup_en_o[p]
        && !port_power_sense_pin_o[p];
    endproperty
    a_pin_off: assert property (p_pin_off)
      else $error("port pin not driven low with power off");

    property p_pin_on;
      @(posedge clock_i) disable iff (!nrst_i)
      port_power_on_i[p] |=> port_power_sense_pin_oe_n_o[p] && port_pullup_en_o[p];
    endproperty
    a_pin_on: assert property (p_pin_on)
      else $error("port pin not released with power on");
  end

  property p_tick_spacing;
    @(posedge clock_i) disable iff (!nrst_i)
    r_reg.tick |=> !r_reg.tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("millisecond tick too frequent");

  property p_split_p4;
    @(posedge clock_i) disable iff (!nrst_i)
    (split_superspeed_power_fn_o[GP66] || split_superspeed_power_fn_o[GP5])
      |-> $past(split4_on) && ($past(r_reg.sel4) == SEL_P4_OPT_A
        || $past(r_reg.sel4) == SEL_P4_OPT_B);
  endproperty
  a_split_p4: assert property (p_split_p4)
    else $error("port 4 split pin active without full enable");

  property p_split_p5;
    @(posedge clock_i) disable iff (!nrst_i)
    (split_superspeed_power_fn_o[GP6] || split_superspeed_power_fn_o[GP4])
      |-> $past(split5_on) && ($past(r_reg.sel5) == SEL_P5_OPT_A
        || $past(r_reg.sel5) == SEL_P5_OPT_B);
  endproperty
  a_split_p5: assert property (p_split_p5)
    else $error("port 5 split pin active without full enable");

  property p_en_write;
    @(posedge clock_i) disable iff (!nrst_i)
    (wr_ok && cfg_req_i.addr == ADDR_SPLIT_EN)
      |=> r_reg.split_en == ($past(cfg_req_i.wdata) & SPLIT_EN_MASK);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("split enable reserved bits not masked");

  property p_cfg_locked;
    @(posedge clock_i) disable iff (!nrst_i)
    (cfg_req_i.wr && !cfg_stage_i && !cfg_req_i.otp)
      |=> $stable(r_reg.split_en) && $stable(r_reg.glob) && $stable(r_reg.sel4);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked)
    else $error("split configuration changed outside configuration stage");

  property p_ss_output;
    @(posedge clock_i) disable iff (!nrst_i)
    (r_next.gpio_fn[GP66] && !ss_power_on_i[0]) |=> !split_superspeed_power_pin_o[GP66];
  endproperty
  a_ss_output: assert property (p_ss_output)
    else $error("split pin not following superspeed power request");
endmodule : pps_top
`default_nettype wire

// file: verification/pps_switch_model.sv
/*
  Model of the external port power switches behind the control pins.
  Assumes the hub drives the pins from its core clock domain.
*/
`default_nettype none
module pps_switch_model
  import pps_pkg::*;
(
  input wire logic [NUM_PORTS-1:0] pin_drive_i,
  input wire logic [NUM_PORTS-1:0] pin_oe_n_i,
  input wire logic [NUM_PORTS-1:0] pullup_en_i,
  input wire logic [NUM_PORTS-1:0] fault_i,
  input wire logic gang_i,
  output logic [NUM_PORTS-1:0] pin_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_PORTS-1:0] own_level;
  // Hub drive wins; a released pin is pulled high while its pull-up is enabled, unless the switch pulls it low
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (!pin_oe_n_i[i])
        own_level[i] = pin_drive_i[i];
      else
        own_level[i] = pullup_en_i[i] & ~fault_i[i];
    end
    // Ganged board: all control pins tied into one wired-AND node
    pin_level_o = gang_i ? {NUM_PORTS{&own_level}} : own_level;
  end
endmodule // pps_switch_model
`default_nettype wire

// file: verification/tb_pps_top.sv
/*
  Self-checking bench for the port power, overcurrent and split block.
  Assumes a 10 cycle tick so that one millisecond is ten clocks.
*/
`default_nettype none
module tb_pps_top
  import pps_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, nrst_i, stage, gang;
  pps_cfg_req_t req;
  logic [7:0] rdata;
  logic [NUM_PORTS-1:0] pwr, sense, pin_o, oe_n, pu, ev, trip, fault;
  logic [1:0] ss;
  logic [NUM_SPLIT_GPIO-1:0] sp_pin, sp_fn;
  int num_errors = 0;
  int n_checks = 0;
  int ev_cnt [NUM_PORTS];
  logic [15:0] sa [4] = '{ADDR_SEL_P4, ADDR_SEL_P4, ADDR_SEL_P5, ADDR_SEL_P5};
  logic [7:0] sv [4] = '{SEL_P4_OPT_A, SEL_P4_OPT_B, SEL_P5_OPT_A, SEL_P5_OPT_B};
  logic [7:0] se [4] = '{8'h20, 8'h20, 8'h40, 8'h40};
  int gi [4] = '{GP66, GP5, GP6, GP4};

  pps_top #(.TICK_CYCLES_P(10)) i_pps_top (
    .clock_i(clock_i), .nrst_i(nrst_i), .cfg_req_i(req), .cfg_stage_i(stage),
    .cfg_rdata_o(rdata), .port_power_on_i(pwr), .ss_power_on_i(ss),
    .port_power_sense_pin_i(sense), .port_power_sense_pin_o(pin_o),
    .port_power_sense_pin_oe_n_o(oe_n), .port_pullup_en_o(pu),
    .overcurrent_event_o(ev), .overcurrent_tripped_o(trip),
    .split_superspeed_power_pin_o(sp_pin), .split_superspeed_power_fn_o(sp_fn));

  pps_switch_model i_pps_switch_model (
    .pin_drive_i(pin_o), .pin_oe_n_i(oe_n), .pullup_en_i(pu),
    .fault_i(fault), .gang_i(gang), .pin_level_o(sense));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    for (int i = 0; i < NUM_PORTS; i++)
      if (ev[i] === 1'b1) ev_cnt[i]++;
  end

  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic ck(input logic [7:0] g, input logic [7:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic o = 1'b0);
    req = '{wr: 1'b1, rd: 1'b0, otp: o, addr: a, wdata: d};
    cy(1);
    req = '0;
    cy(1);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string m);
    req = '{wr: 1'b0, rd: 1'b1, otp: 1'b0, addr: a, wdata: 8'h00};
    cy(1);
    req = '0;
    cy(1);
    ck(rdata, e, m);
  endtask

  task automatic pulse(input int p);
    fault[p] = 1'b1;
    cy(3);
    fault[p] = 1'b0;
  endtask

  initial begin
    repeat (5000) @(posedge clock_i);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  initial begin
    nrst_i = 1'b0;
    stage = 1'b1;
    req = '0;
    pwr = '0;
    ss = '0;
    fault = '0;
    gang = 1'b0;
    repeat (6) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    rd(ADDR_LOCKOUT, RST_LOCKOUT, "lockout reset");
    rd(ADDR_WINDOW, RST_WINDOW, "window reset");
    rd(ADDR_MIN_WIDTH, 8'h05, "width reset");
    rd(ADDR_SPLIT_EN, 8'h00, "split reset");
    rd(ADDR_GLOBAL, 8'h00, "global reset");
    rd(16'h1234, 8'h00, "unmapped read");
    ck({2'h0, oe_n}, 8'h00, "driven while off");
    ck({2'h0, pin_o}, 8'h00, "drive low");
    wr(ADDR_SPLIT_EN, 8'hFF);
    rd(ADDR_SPLIT_EN, 8'h60, "split mask");
    wr(ADDR_GLOBAL, 8'hFF);
    rd(ADDR_GLOBAL, 8'h01, "global mask");
    stage = 1'b0;
    wr(ADDR_LOCKOUT, 8'h33);
    rd(ADDR_LOCKOUT, 8'h0A, "outside stage");
    wr(ADDR_LOCKOUT, 8'h04, 1'b1);
    rd(ADDR_LOCKOUT, 8'h04, "otp load");
    stage = 1'b1;
    wr(ADDR_WINDOW, 8'h05);
    wr(ADDR_MIN_WIDTH, 8'h01);
    wr(ADDR_SPLIT_EN, 8'h00);
    wr(ADDR_GLOBAL, 8'h00);
    // Low during lockout must be ignored, a long low afterwards trips
    pwr[0] = 1'b1;
    fault[0] = 1'b1;
    cy(1);
    ck({2'h0, oe_n}, 8'h01, "released");
    ck({2'h0, pu}, 8'h01, "pullup");
    cy(11);
    fault[0] = 1'b0;
    cy(60);
    ck(8'(ev_cnt[0]), 8'h00, "lockout");
    fault[0] = 1'b1;
    cy(30);
    fault[0] = 1'b0;
    cy(3);
    ck(8'(ev_cnt[0]), 8'h01, "single pulse");
    ck({7'h0, trip[0]}, 8'h01, "tripped");
    pwr[0] = 1'b0;
    cy(3);
    ck({7'h0, trip[0]}, 8'h00, "trip clear");
    // Double short pulses, first pair outside the window
    wr(ADDR_MIN_WIDTH, 8'h02);
    pwr[1] = 1'b1;
    fault[2] = 1'b1;
    cy(60);
    pulse(1);
    cy(80);
    pulse(1);
    cy(20);
    ck(8'(ev_cnt[1]), 8'h00, "window expired");
    pulse(1);
    cy(10);
    ck(8'(ev_cnt[1]), 8'h01, "double pulse");
    ck(8'(ev_cnt[2]), 8'h00, "unpowered port");
    fault[2] = 1'b0;
    // Split routing
    wr(ADDR_SEL_P4, SEL_P4_OPT_A);
    wr(ADDR_SPLIT_EN, 8'h20);
    cy(2);
    ck({4'h0, sp_fn}, 8'h00, "no global");
    wr(ADDR_GLOBAL, 8'h01);
    pwr[PORT4_IDX] = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SEL_P4, 8'h00);
      wr(ADDR_SEL_P5, 8'h00);
      wr(sa[k], sv[k]);
      wr(ADDR_SPLIT_EN, se[k]);
      ss = 2'b00;
      cy(2);
      ck({4'h0, sp_fn}, 8'(1 << gi[k]), "split fn");
      ck({4'h0, sp_pin}, 8'h00, "split idle");
      ss = 2'b11;
      cy(2);
      ck({4'h0, sp_pin}, 8'(1 << gi[k]), "split pin");
    end
    ck({7'h0, oe_n[PORT4_IDX]}, 8'h01, "usb2 half");
    wr(ADDR_SEL_P4, 8'h11);
    wr(ADDR_SEL_P5, 8'h11);
    wr(ADDR_SPLIT_EN, 8'h60);
    cy(2);
    ck({4'h0, sp_fn}, 8'h00, "bad select");
    // Ganged board: one blown fuse pulls every tied pin low
    pwr = '0;
    cy(3);
    gang = 1'b1;
    pwr = '1;
    cy(60);
    fault[5] = 1'b1;
    cy(40);
    ck({2'h0, trip}, 8'h3F, "ganged trip");
    fault[5] = 1'b0;
    gang = 1'b0;
    nrst_i = 1'b0;
    cy(2);
    nrst_i = 1'b1;
    rd(ADDR_GLOBAL, 8'h00, "second reset");
    results();
  end
endmodule // tb_pps_top
`default_nettype wire
